/* design/cfl_map.vh */
// constants for the copper/fiber link fault control block
`ifndef CFL_MAP_VH
`define CFL_MAP_VH
`define CFL_CLK_HZ 20000000
`define CFL_BLINK_MS 50
`define CFL_BLINK_CYC ((`CFL_CLK_HZ / 1000) * `CFL_BLINK_MS)
`define CFL_FIB_RATE_MBPS 1000
`define CFL_ADDR_CTRL 4'h0
`define CFL_ADDR_STAT 4'h1
`define CFL_CTRL_LFP_BIT 0
`define CFL_CTRL_FEF_BIT 1
`define CFL_CTRL_RST 2'h3
`endif

/* design/cfl_top.v */
// link fault pass-through, far end fault and indicator control
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "cfl_map.vh"
module cfl_top #(
  parameter DATA_W = 8,
  parameter BLINK_CYC = `CFL_BLINK_CYC
) (
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire cu_link_ok,
  input wire fib_link_ok,
  input wire fib_rx_fail,
  input wire fib_far_fault_rx,
  input wire fib_sig_detect,
  input wire mod_present,
  input wire [DATA_W-1:0] cu_rx_data,
  input wire cu_rx_dv,
  input wire cu_rx_er,
  input wire [DATA_W-1:0] fib_rx_data,
  input wire fib_rx_dv,
  input wire fib_rx_er,
  output reg [DATA_W-1:0] fib_tx_data,
  output reg fib_tx_en,
  output reg fib_tx_er,
  output reg [DATA_W-1:0] cu_tx_data,
  output reg cu_tx_en,
  output reg cu_tx_er,
  output reg cu_force_down,
  output reg fib_force_down,
  output reg fib_far_fault_tx,
  output reg fib_full_duplex,
  output reg fib_speed_1000,
  output reg link_indicator,
  output reg optical_signal_indicator,
  output reg module_indicator
);

////////////////////////////////////////////////////////////////////////
// control bits: pass-through and far end fault enables, both on from reset
reg lfp_en_reg;
reg fef_en_reg;
wire ctrl_wr_hit = reg_wr && (reg_addr == `CFL_ADDR_CTRL);
wire lfp_en_next = reg_wdata[`CFL_CTRL_LFP_BIT];
wire fef_en_next = reg_wdata[`CFL_CTRL_FEF_BIT];
wire [1:0] ctrl_rst = `CFL_CTRL_RST;

always @(posedge ref_clk) begin
  if (!rst_n) begin
    lfp_en_reg <= ctrl_rst[`CFL_CTRL_LFP_BIT];
  end else if (clk_en && ctrl_wr_hit) begin
    lfp_en_reg <= lfp_en_next;
  end
end

always @(posedge ref_clk) begin
  if (!rst_n) begin
    fef_en_reg <= ctrl_rst[`CFL_CTRL_FEF_BIT];
  end else if (clk_en && ctrl_wr_hit) begin
    fef_en_reg <= fef_en_next;
  end
end

////////////////////////////////////////////////////////////////////////
// fault evaluation: fiber counts as down on own loss, receive or remote fault
reg fib_up;
reg path_up;

always @* begin
  fib_up = fib_link_ok;
  if (fib_rx_fail) begin
    fib_up = 1'b0;
  end
  if (fef_en_reg && fib_far_fault_rx) begin
    fib_up = 1'b0;
  end
  path_up = cu_link_ok && fib_up;
end

// plain levels, registered once, so a forced down drops one cycle after its cause clears
reg fib_force_down_next;
reg cu_force_down_next;
reg fib_far_fault_tx_next;

always @* begin
  fib_force_down_next = 1'b0;
  cu_force_down_next = 1'b0;
  fib_far_fault_tx_next = 1'b0;
  if (lfp_en_reg) begin
    fib_force_down_next = !cu_link_ok;
    cu_force_down_next = !fib_up;
  end
  if (fef_en_reg) begin
    fib_far_fault_tx_next = fib_rx_fail;
  end
end

////////////////////////////////////////////////////////////////////////
// forwarding gates: tx enable and error follow rx only while both links are up
reg fib_tx_en_next;
reg fib_tx_er_next;
reg cu_tx_en_next;
reg cu_tx_er_next;

always @* begin
  fib_tx_en_next = 1'b0;
  fib_tx_er_next = 1'b0;
  cu_tx_en_next = 1'b0;
  cu_tx_er_next = 1'b0;
  if (path_up) begin
    fib_tx_en_next = cu_rx_dv;
    fib_tx_er_next = cu_rx_er;
    cu_tx_en_next = fib_rx_dv;
    cu_tx_er_next = fib_rx_er;
  end
end

////////////////////////////////////////////////////////////////////////
// traffic stretch counter
localparam CNT_W = 24;
reg [CNT_W-1:0] blink_cnt_reg;
reg [CNT_W-1:0] blink_cnt_next;
reg blink_phase_reg;
reg blink_phase_next;
wire activity = cu_rx_dv || fib_rx_dv;
wire link_indicator_next = path_up && !blink_phase_reg;

always @* begin
  blink_cnt_next = blink_cnt_reg;
  blink_phase_next = blink_phase_reg;
  if (blink_cnt_reg != {CNT_W{1'b0}}) begin
    blink_cnt_next = blink_cnt_reg - 1'b1;
  end else if (activity && path_up) begin
    // one full toggle per period keeps the blink visible at line rate
    blink_cnt_next = BLINK_CYC[CNT_W-1:0];
    blink_phase_next = ~blink_phase_reg;
  end else begin
    blink_phase_next = 1'b0;
  end
end

always @(posedge ref_clk) begin
  if (!rst_n) begin
    blink_cnt_reg <= {CNT_W{1'b0}};
  end else if (clk_en) begin
    blink_cnt_reg <= blink_cnt_next;
  end
end

always @(posedge ref_clk) begin
  if (!rst_n) begin
    blink_phase_reg <= 1'b0;
  end else if (clk_en) begin
    blink_phase_reg <= blink_phase_next;
  end
end

////////////////////////////////////////////////////////////////////////
// status word for software, taken on the read strobe
wire [5:0] stat_bits = {mod_present, fib_sig_detect, fib_far_fault_rx,
                        fib_rx_fail, fib_up, cu_link_ok};

////////////////////////////////////////////////////////////////////////
// fiber transmit data: one register stage, no buffer, so no drops
always @(posedge ref_clk) begin
  if (!rst_n) begin
    fib_tx_data <= {DATA_W{1'b0}};
  end else if (clk_en) begin
    fib_tx_data <= cu_rx_data;
  end
end

////////////////////////////////////////////////////////////////////////
// fiber transmit enable
always @(posedge ref_clk) begin
  if (!rst_n) begin
    fib_tx_en <= 1'b0;
  end else if (clk_en) begin
    fib_tx_en <= fib_tx_en_next;
  end
end

////////////////////////////////////////////////////////////////////////
// fiber transmit error
always @(posedge ref_clk) begin
  if (!rst_n) begin
    fib_tx_er <= 1'b0;
  end else if (clk_en) begin
    fib_tx_er <= fib_tx_er_next;
  end
end

////////////////////////////////////////////////////////////////////////
// copper transmit data
always @(posedge ref_clk) begin
  if (!rst_n) begin
    cu_tx_data <= {DATA_W{1'b0}};
  end else if (clk_en) begin
    cu_tx_data <= fib_rx_data;
  end
end

////////////////////////////////////////////////////////////////////////
// copper transmit enable
always @(posedge ref_clk) begin
  if (!rst_n) begin
    cu_tx_en <= 1'b0;
  end else if (clk_en) begin
    cu_tx_en <= cu_tx_en_next;
  end
end

////////////////////////////////////////////////////////////////////////
// copper transmit error
always @(posedge ref_clk) begin
  if (!rst_n) begin
    cu_tx_er <= 1'b0;
  end else if (clk_en) begin
    cu_tx_er <= cu_tx_er_next;
  end
end

////////////////////////////////////////////////////////////////////////
// fiber forced down
always @(posedge ref_clk) begin
  if (!rst_n) begin
    fib_force_down <= 1'b0;
  end else if (clk_en) begin
    fib_force_down <= fib_force_down_next;
  end
end

////////////////////////////////////////////////////////////////////////
// copper forced down
always @(posedge ref_clk) begin
  if (!rst_n) begin
    cu_force_down <= 1'b0;
  end else if (clk_en) begin
    cu_force_down <= cu_force_down_next;
  end
end

////////////////////////////////////////////////////////////////////////
// far end fault sent to the fiber partner
always @(posedge ref_clk) begin
  if (!rst_n) begin
    fib_far_fault_tx <= 1'b0;
  end else if (clk_en) begin
    fib_far_fault_tx <= fib_far_fault_tx_next;
  end
end

////////////////////////////////////////////////////////////////////////
// fiber duplex: full only
always @(posedge ref_clk) begin
  if (!rst_n) begin
    fib_full_duplex <= 1'b1;
  end else if (clk_en) begin
    fib_full_duplex <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////
// fiber speed: one rate only
always @(posedge ref_clk) begin
  if (!rst_n) begin
    fib_speed_1000 <= 1'b1;
  end else if (clk_en) begin
    fib_speed_1000 <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////
// link indicator
always @(posedge ref_clk) begin
  if (!rst_n) begin
    link_indicator <= 1'b0;
  end else if (clk_en) begin
    link_indicator <= link_indicator_next;
  end
end

////////////////////////////////////////////////////////////////////////
// optical indicator
always @(posedge ref_clk) begin
  if (!rst_n) begin
    optical_signal_indicator <= 1'b0;
  end else if (clk_en) begin
    optical_signal_indicator <= fib_sig_detect;
  end
end

////////////////////////////////////////////////////////////////////////
// transceiver slot indicator
always @(posedge ref_clk) begin
  if (!rst_n) begin
    module_indicator <= 1'b0;
  end else if (clk_en) begin
    module_indicator <= mod_present;
  end
end

////////////////////////////////////////////////////////////////////////
// register read: data stand one cycle after the strobe, zero otherwise
always @(posedge ref_clk) begin
  if (!rst_n) begin
    reg_rdata <= 32'h00000000;
  end else if (clk_en) begin
    if (reg_rd) begin
      case (reg_addr)
        `CFL_ADDR_CTRL: begin
          reg_rdata <= {30'h0, fef_en_reg, lfp_en_reg};
        end
        `CFL_ADDR_STAT: begin
          reg_rdata <= {26'h0, stat_bits};
        end
        default: begin
          // unmapped addresses read as zero
          reg_rdata <= 32'h00000000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
end

endmodule

/* test/cfl_top_asserts.sv */
// assertions on the link fault control block ports
`timescale 1ns/1ns
module cfl_top_asserts (input ref_clk, rst_n, clk_en, cu_link_ok, fib_link_ok, fib_rx_fail,
  input fib_far_fault_rx, fib_sig_detect, mod_present, cu_force_down, fib_force_down,
  input fib_far_fault_tx, link_indicator, optical_signal_indicator, module_indicator);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_fib_down: assert property (clk_en && !cu_link_ok |=> fib_force_down)
    else $error("fib up");
  a_cu_down: assert property (clk_en && !fib_link_ok |=> cu_force_down)
    else $error("cu up");
  a_fef_send: assert property (clk_en && fib_rx_fail |=> fib_far_fault_tx)
    else $error("no fef");
  a_fef_take: assert property (clk_en && fib_far_fault_rx |=> cu_force_down)
    else $error("fef");
  a_link_dark: assert property (clk_en && !cu_link_ok |=> !link_indicator)
    else $error("lit");
  a_opt_lamp: assert property (clk_en |=> optical_signal_indicator == $past(fib_sig_detect))
    else $error("opt");
  a_mod_lamp: assert property (clk_en |=> module_indicator == $past(mod_present))
    else $error("mod");
  a_fault_clear: assert property (clk_en && $rose(cu_link_ok) |=> !fib_force_down)
    else $error("held");
endmodule
bind cfl_top cfl_top_asserts i_chk (.*);

/* test/cfl_partner.sv */
// copper-side partner streaming back-to-back bytes
`timescale 1ns/1ns
module cfl_partner (input ref_clk, send, output logic cu_rx_dv = 1'h0,
  output logic [7:0] cu_rx_data = 8'h00);
  always @(posedge ref_clk) cu_rx_dv <= send;
  always @(posedge ref_clk) cu_rx_data <= cu_rx_data + 8'h01; // idle bytes keep changing
endmodule

/* test/cfl_top_tb.sv */
// self-checking bench for the link fault control block
`timescale 1ns/1ns
module cfl_top_tb;
  logic ref_clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, cu_rx_er = 0, fib_rx_er = 0;
  logic send, cu_rx_dv, fib_rx_dv, fib_tx_en, fib_tx_er, cu_tx_en, cu_tx_er, cu_force_down;
  logic fib_force_down, fib_far_fault_tx, fib_full_duplex, fib_speed_1000, link_indicator;
  logic optical_signal_indicator, module_indicator, cu_link_ok, fib_link_ok, fib_rx_fail;
  logic fib_far_fault_rx, fib_sig_detect, mod_present;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0] cu_rx_data, fib_rx_data, fib_tx_data, cu_tx_data;
  logic [6:0] st = 7'h03;
  logic [4:0] fv;
  logic [8:0] tbl [8] = '{9'h192, 9'h198, 9'h18C, 9'h198, 9'h1BD, 9'h198, 9'h1DC, 9'h198};
  int n_errors = 0, samples_checked = 0, cyc = 0, n_dark = 0;
  assign {send,mod_present,fib_sig_detect,fib_far_fault_rx,fib_rx_fail,fib_link_ok,cu_link_ok} = st;
  assign {fib_rx_data, fib_rx_dv} = {cu_rx_data, cu_rx_dv};
  assign fv = {fib_full_duplex, fib_speed_1000, cu_force_down, fib_force_down, fib_far_fault_tx};
  always #25 ref_clk = ~ref_clk;
  cfl_top #(.BLINK_CYC(4)) i_dut (.*);
  cfl_partner i_peer (.*);
  task finish_test;
    n_errors += (cyc >= 500);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, g);
    samples_checked++;
    n_errors += (g !== e);
    if (g !== e) $display("wrong value %s expected %0h seen %0h", nm, e, g);
  endtask
  task acc(input [3:0] a, input w, input [31:0] d);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
    @(posedge ref_clk);
    {reg_wr, reg_rd} <= 2'h0;
    #1 if (!w) chk("reg_rdata", d, reg_rdata); // data stands one cycle only
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) if (++cyc == 500) finish_test;
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1;
    acc(4'h0, 0, 32'h3);
    acc(4'h9, 1, 32'h0);
    acc(4'h0, 1, 32'h3);
    acc(4'h9, 0, 32'h0);
    acc(4'h1, 0, 32'h3);
    {st, cu_rx_er, fib_rx_er} <= {7'h73, 2'h3};
    repeat (8) @(posedge ref_clk);
    #1 chk("fwd", {cu_rx_data, cu_rx_data, 4'hF},
      {fib_tx_data + 8'h01, cu_tx_data + 8'h01, fib_tx_en, cu_tx_en, fib_tx_er, cu_tx_er});
    repeat (10) begin
      @(posedge ref_clk);
      #1 n_dark += !link_indicator;
    end
    chk("blink", 32'h5, n_dark);
    @(posedge ref_clk);
    {st, cu_rx_er, fib_rx_er} <= {7'h33, 2'h0};
    repeat (8) @(posedge ref_clk);
    #1 chk("lamps", 32'hE,
      {link_indicator, optical_signal_indicator, module_indicator, fib_tx_en});
    @(posedge ref_clk);
    st <= 7'h72;
    repeat (3) @(posedge ref_clk);
    #1 chk("gate", 32'h0, {fib_tx_en, cu_tx_en, link_indicator});
    foreach (tbl[i]) begin
      @(posedge ref_clk);
      st <= {1'h0, tbl[i][8:3]};
      repeat (2) @(posedge ref_clk);
      #1 chk("fault", {2'h3, tbl[i][2:0]}, fv);
    end
    @(posedge ref_clk);
    {clk_en, st} <= {1'h0, 7'h03};
    repeat (3) @(posedge ref_clk);
    #1 chk("freeze", 32'h3, {optical_signal_indicator, module_indicator});
    @(posedge ref_clk);
    clk_en <= 1;
    repeat (2) @(posedge ref_clk);
    #1 chk("thaw", 32'h0, {optical_signal_indicator, module_indicator});
    finish_test;
  end
endmodule
